// ===== hw/timer8_waveform_modes.sv
// 8-bit timer/counter with one compare channel and four waveform modes
//
// Added by the designer: the address map and the plain strobed port.
`timescale 1ns/1ps
module timer8_waveform_modes
(
  input  wire logic       clk_i,
  input  wire logic       sys_rst_i,
  input  wire logic [1:0] addr_i,
  input  wire logic [7:0] wdata_i,
  input  wire logic       wr_i,
  input  wire logic       rd_i,
  input  wire logic       tick_i,
  input  wire logic       pin_dir_out_i,
  output logic      [7:0] rdata_o,
  output logic            wave_pin_o,
  output logic            wave_pin_oe_o,
  output logic            overflow_flag_o,
  output logic            match_flag_o
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] count;
    logic       down;
    logic [7:0] ocr;
    logic [7:0] ocr_buf;
    logic [1:0] mode;
    logic [1:0] act;
    logic [2:0] csel;
    logic       wave;
    logic       ovf;
    logic       mch;
    logic       pend;
    logic       blk;
    logic       up_hit;
    logic [7:0] rdata;
    logic       pin;
    logic       oe;
  } state_s;

  state_s st_ff;
  state_s nxt_st;

  logic tick;
  logic match;
  logic at_max;
  logic at_bot;
  logic up_match;
  logic ovf_set;
  logic mch_set;
  logic ovf_clr;
  logic mch_clr;
  logic wr_count;

  assign tick     = tick_i && (st_ff.csel != timer8_pkg::CSEL_STOP);
  assign match    = (st_ff.count == st_ff.ocr) && !st_ff.blk;
  assign at_max   = (st_ff.count == timer8_pkg::COUNT_MAX);
  assign at_bot   = (st_ff.count == timer8_pkg::COUNT_BOT);
  // Turnaround points count as the slope that leaves them
  assign up_match = match && ((!st_ff.down && !at_max) || at_bot);
  assign wr_count = wr_i && (addr_i == timer8_pkg::ADDR_COUNT);
  assign ovf_clr  = wr_i && (addr_i == timer8_pkg::ADDR_FLAGS) && wdata_i[timer8_pkg::OVF_BIT];
  assign mch_clr  = wr_i && (addr_i == timer8_pkg::ADDR_FLAGS) && wdata_i[timer8_pkg::MCH_BIT];

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    nxt_st  = st_ff;
    ovf_set = 1'b0;
    mch_set = 1'b0;
    if (tick)
    begin
      nxt_st.blk  = 1'b0;
      nxt_st.pend = match;
      mch_set     = st_ff.pend;
      case (st_ff.mode)
        timer8_pkg::MODE_NORMAL:
        begin
          nxt_st.count = st_ff.count + 8'h01;
          ovf_set      = at_max;
        end
        timer8_pkg::MODE_CLEAR:
        begin
          if (match)
            nxt_st.count = timer8_pkg::COUNT_BOT;
          else
            nxt_st.count = st_ff.count + 8'h01;
          ovf_set = at_max && !match;
        end
        timer8_pkg::MODE_FAST:
        begin
          nxt_st.count = st_ff.count + 8'h01;
          if (at_max)
          begin
            ovf_set    = 1'b1;
            nxt_st.ocr = st_ff.ocr_buf;
          end
        end
        timer8_pkg::MODE_PHASE:
        begin
          if (!st_ff.down)
          begin
            if (at_max)
            begin
              nxt_st.down  = 1'b1;
              nxt_st.count = st_ff.count - 8'h01;
              nxt_st.ocr   = st_ff.ocr_buf;
            end
            else
              nxt_st.count = st_ff.count + 8'h01;
          end
          else if (at_bot)
          begin
            nxt_st.down  = 1'b0;
            nxt_st.count = st_ff.count + 8'h01;
            ovf_set      = 1'b1;
          end
          else
            nxt_st.count = st_ff.count - 8'h01;
        end
        default:
          nxt_st.count = st_ff.count;
      endcase

      // Waveform generation; the reserved toggle setting does nothing in mode 1
      case (st_ff.mode)
        timer8_pkg::MODE_NORMAL, timer8_pkg::MODE_CLEAR:
        begin
          if (match)
          begin
            case (st_ff.act)
              timer8_pkg::ACT_TOGGLE: nxt_st.wave = !st_ff.wave;
              timer8_pkg::ACT_CLR:    nxt_st.wave = 1'b0;
              timer8_pkg::ACT_SET:    nxt_st.wave = 1'b1;
              default:                nxt_st.wave = st_ff.wave;
            endcase
          end
        end
        timer8_pkg::MODE_FAST:
        begin
          if (st_ff.act == timer8_pkg::ACT_TOGGLE)
          begin
            if (match)
              nxt_st.wave = !st_ff.wave;
          end
          else if (st_ff.act[1])
          begin
            // Compare at max: match dropped, bottom level wins for a flat output
            if (match && (st_ff.ocr != timer8_pkg::COUNT_MAX))
              nxt_st.wave = st_ff.act[0];
            if (at_max)
              nxt_st.wave = !st_ff.act[0];
          end
        end
        timer8_pkg::MODE_PHASE:
        begin
          if (st_ff.act[1])
          begin
            if (at_bot && st_ff.down)
              nxt_st.up_hit = 1'b0;
            if (match)
              nxt_st.wave = up_match ? st_ff.act[0] : !st_ff.act[0];
            if (up_match)
              nxt_st.up_hit = 1'b1;
            // Up-slope change missed or compare leaving max: restore symmetry
            if (at_max && !st_ff.down && !st_ff.up_hit
                && (st_ff.ocr_buf != timer8_pkg::COUNT_MAX))
              nxt_st.wave = st_ff.act[0];
          end
        end
        default:
          nxt_st.wave = st_ff.wave;
      endcase
    end

    // Software writes to control, count and compare win over counting
    if (wr_i)
    begin
      case (addr_i)
        timer8_pkg::ADDR_CTRL:
        begin
          nxt_st.mode = wdata_i[timer8_pkg::MODE_LSB +: 2];
          nxt_st.act  = wdata_i[timer8_pkg::ACT_LSB +: 2];
          nxt_st.csel = wdata_i[timer8_pkg::CSEL_LSB +: 3];
        end
        timer8_pkg::ADDR_COUNT:
        begin
          nxt_st.count = wdata_i;
          nxt_st.blk   = 1'b1;
        end
        timer8_pkg::ADDR_COMPARE:
        begin
          nxt_st.ocr_buf = wdata_i;
          if (!st_ff.mode[0])
            nxt_st.ocr = wdata_i;
        end
        default:
          nxt_st.blk = nxt_st.blk;
      endcase
    end

    // Set beats a simultaneous clear
    nxt_st.ovf = (st_ff.ovf && !ovf_clr) || ovf_set;
    nxt_st.mch = (st_ff.mch && !mch_clr) || mch_set;

    nxt_st.rdata = 8'h00;
    if (rd_i)
    begin
      case (addr_i)
        timer8_pkg::ADDR_CTRL:
          nxt_st.rdata = {1'b0, st_ff.csel, st_ff.act, st_ff.mode};
        timer8_pkg::ADDR_COUNT:
          nxt_st.rdata = st_ff.count;
        timer8_pkg::ADDR_COMPARE:
          nxt_st.rdata = st_ff.mode[0] ? st_ff.ocr_buf : st_ff.ocr;
        default:
          nxt_st.rdata = {6'h00, st_ff.mch, st_ff.ovf};
      endcase
    end

    nxt_st.pin = st_ff.wave;
    nxt_st.oe  = pin_dir_out_i && (st_ff.act != timer8_pkg::ACT_OFF);
  end

  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
      st_ff <= '0;
    else
      st_ff <= nxt_st;
  end

  assign rdata_o         = st_ff.rdata;
  assign wave_pin_o      = st_ff.pin;
  assign wave_pin_oe_o   = st_ff.oe;
  assign overflow_flag_o = st_ff.ovf;
  assign match_flag_o    = st_ff.mch;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence s_pend_tick;
    tick && st_ff.pend && !mch_clr;
  endsequence

  sequence s_mch_up;
    st_ff.mch;
  endsequence

  AST_MODE0_WRAP: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    tick && st_ff.mode == timer8_pkg::MODE_NORMAL && at_max && !wr_i
    |=> st_ff.count == 8'h00 && st_ff.ovf)
    else $error("mode 0 did not wrap with overflow");

  AST_OVF_STICKY: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    st_ff.ovf && !ovf_clr |=> st_ff.ovf)
    else $error("overflow flag cleared without software");

  AST_CLEAR_TOP: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    tick && st_ff.mode == timer8_pkg::MODE_CLEAR && match && !wr_i
    |=> st_ff.count == 8'h00)
    else $error("clear-on-match did not clear");

  AST_MATCH_FLAG: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    s_pend_tick |=> s_mch_up)
    else $error("match flag not set one timer cycle later");

  AST_CLEAR_TOGGLE: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    tick && st_ff.mode == timer8_pkg::MODE_CLEAR && st_ff.act == timer8_pkg::ACT_TOGGLE
    && match |=> st_ff.wave != $past(st_ff.wave) ##1 st_ff.pin == $past(st_ff.wave))
    else $error("toggle on match missing");

  AST_PIN_HIDDEN: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    !pin_dir_out_i |=> !wave_pin_oe_o)
    else $error("pin driven while direction is input");

  AST_FAST_BOTTOM: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    tick && st_ff.mode == timer8_pkg::MODE_FAST && st_ff.act == timer8_pkg::ACT_CLR
    && at_max |=> st_ff.wave)
    else $error("bottom set missing in fast mode");

  AST_PHASE_TOP: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    tick && st_ff.mode == timer8_pkg::MODE_PHASE && at_max && !st_ff.down && !wr_i
    |=> st_ff.count == 8'hFE && st_ff.down)
    else $error("phase mode did not turn at max");

  AST_PHASE_OVF: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    tick && st_ff.mode == timer8_pkg::MODE_PHASE && at_bot && st_ff.down && !wr_i
    |=> st_ff.ovf && st_ff.count == 8'h01)
    else $error("phase mode overflow at bottom missing");

  AST_STOPPED: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    st_ff.csel == timer8_pkg::CSEL_STOP && !wr_i |=> $stable(st_ff.count))
    else $error("counter moved while stopped");

  AST_BUFFERED: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    st_ff.mode == timer8_pkg::MODE_FAST && !(tick && at_max) |=> $stable(st_ff.ocr))
    else $error("compare changed outside top in fast mode");

  AST_CLR_W1: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    mch_clr && !(tick && st_ff.pend) |=> !st_ff.mch)
    else $error("write one did not clear match flag");

  AST_CLEAR_FLAG: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    tick && st_ff.mode == timer8_pkg::MODE_CLEAR && match |=> st_ff.pend)
    else $error("clear-on-match top did not arm the match flag");

  AST_CLEAR_OVF: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    tick && st_ff.mode == timer8_pkg::MODE_CLEAR && at_max && !match && !wr_i
    |=> st_ff.count == timer8_pkg::COUNT_BOT && st_ff.ovf)
    else $error("clear-on-match mode missed overflow at wrap");

  AST_FAST_WRAP: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    tick && st_ff.mode == timer8_pkg::MODE_FAST && at_max && !wr_i
    |=> st_ff.count == timer8_pkg::COUNT_BOT && st_ff.ovf)
    else $error("fast mode did not wrap with overflow");

  AST_FAST_MATCH: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    tick && st_ff.mode == timer8_pkg::MODE_FAST && st_ff.act[1] && match && !at_max
    |=> st_ff.wave == $past(st_ff.act[0]))
    else $error("fast mode match action wrong");

  AST_PHASE_DOWN: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    tick && st_ff.mode == timer8_pkg::MODE_PHASE && st_ff.act[1] && match
    && st_ff.down && !at_bot |=> st_ff.wave != $past(st_ff.act[0]))
    else $error("phase mode down-count match action wrong");

  AST_PHASE_SYM: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    tick && st_ff.mode == timer8_pkg::MODE_PHASE && st_ff.act[1] && at_max && !st_ff.down
    && !st_ff.up_hit && st_ff.ocr_buf != timer8_pkg::COUNT_MAX
    |=> st_ff.wave == $past(st_ff.act[0]))
    else $error("phase mode turnaround did not restore symmetry");

  AST_PHASE_LOAD: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    tick && st_ff.mode == timer8_pkg::MODE_PHASE && at_max && !st_ff.down
    |=> st_ff.ocr == $past(st_ff.ocr_buf))
    else $error("phase mode compare not loaded at top");

  AST_NO_TICK: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    !tick && !wr_i |=> $stable(st_ff.count) && $stable(st_ff.wave))
    else $error("counter or waveform moved without a timer enable");

endmodule

// ===== hw/timer8_pkg.sv
// Constants shared by the 8-bit waveform timer
package timer8_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam int          ADDR_W       = 2;
  localparam logic [1:0]  ADDR_CTRL    = 2'h0;
  localparam logic [1:0]  ADDR_COUNT   = 2'h1;
  localparam logic [1:0]  ADDR_COMPARE = 2'h2;
  localparam logic [1:0]  ADDR_FLAGS   = 2'h3;

  // ----------------------------------------------------------------
  // Control field layout
  // ----------------------------------------------------------------
  localparam int          MODE_LSB     = 0;
  localparam int          ACT_LSB      = 2;
  localparam int          CSEL_LSB     = 4;

  // ----------------------------------------------------------------
  // Flag bit positions
  // ----------------------------------------------------------------
  localparam int          OVF_BIT      = 0;
  localparam int          MCH_BIT      = 1;

  // ----------------------------------------------------------------
  // Waveform modes and output actions
  // ----------------------------------------------------------------
  localparam logic [1:0]  MODE_NORMAL  = 2'h0;
  localparam logic [1:0]  MODE_PHASE   = 2'h1;
  localparam logic [1:0]  MODE_CLEAR   = 2'h2;
  localparam logic [1:0]  MODE_FAST    = 2'h3;
  localparam logic [1:0]  ACT_OFF      = 2'h0;
  localparam logic [1:0]  ACT_TOGGLE   = 2'h1;
  localparam logic [1:0]  ACT_CLR      = 2'h2;
  localparam logic [1:0]  ACT_SET      = 2'h3;
  localparam logic [2:0]  CSEL_STOP    = 3'h0;

  // ----------------------------------------------------------------
  // Counter extremes and reset values
  // ----------------------------------------------------------------
  localparam logic [7:0]  COUNT_MAX    = 8'hFF;
  localparam logic [7:0]  COUNT_BOT    = 8'h00;
  localparam logic [7:0]  COUNT_RST    = 8'h00;
  localparam logic [7:0]  COMPARE_RST  = 8'h00;

endpackage

// ===== tb/pin_load_model.sv
// Load hanging on the waveform pin: shows the driven level, drifts when released
`timescale 1ns/1ps
module pin_load_model
(
  input  wire logic clk_i,
  input  wire logic pin_i,
  input  wire logic pin_oe_i,
  output logic      line_o
);
  // No pull on this net, so a released line shows the inverse of the last level
  logic last_ff = 1'b0;

  always_ff @(posedge clk_i)
  begin
    if (pin_oe_i)
    begin
      last_ff <= pin_i;
    end
  end

  assign line_o = pin_oe_i ? pin_i : ~last_ff;
endmodule

// ===== tb/tb_top.sv
// Self-checking bench for the 8-bit waveform timer
`timescale 1ns/1ps
module tb_top;
  logic       clk_i         = 1'b0;
  logic       sys_rst_i     = 1'b1;
  logic [1:0] addr_i        = 2'h0;
  logic [7:0] wdata_i       = 8'h00;
  logic       wr_i          = 1'b0;
  logic       rd_i          = 1'b0;
  logic       tick_i        = 1'b0;
  logic       pin_dir_out_i = 1'b0;
  logic [7:0] rdata_o;
  logic       wave_pin_o;
  logic       wave_pin_oe_o;
  logic       overflow_flag_o;
  logic       match_flag_o;
  logic       line;
  int         miscompares   = 0;
  int         tests_run     = 0;

  always #5 clk_i = ~clk_i;

  timer8_waveform_modes dut_u (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .tick_i(tick_i),
    .pin_dir_out_i(pin_dir_out_i), .rdata_o(rdata_o), .wave_pin_o(wave_pin_o),
    .wave_pin_oe_o(wave_pin_oe_o), .overflow_flag_o(overflow_flag_o),
    .match_flag_o(match_flag_o));

  pin_load_model load_u (.clk_i(clk_i), .pin_i(wave_pin_o), .pin_oe_i(wave_pin_oe_o),
    .line_o(line));

  // ----------------------------------------------------------------
  // Bus and compare tasks
  // ----------------------------------------------------------------
  task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
    tests_run++;
    if (got !== exp)
    begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk1(input string what, input logic exp, input logic got);
    tests_run++;
    if (got !== exp)
    begin
      miscompares++;
      $display("wrong value %s expected %b seen %b", what, exp, got);
    end
  endtask

  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'b1;
    @(posedge clk_i);
    wr_i    <= 1'b0;
    #1;
  endtask

  task automatic rdc(input string what, input logic [1:0] a, input logic [7:0] exp);
    @(posedge clk_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge clk_i);
    rd_i   <= 1'b0;
    #1;
    chk8(what, exp, rdata_o);
  endtask

  task automatic cnt(input logic [7:0] exp);
    rdc("count", timer8_pkg::ADDR_COUNT, exp);
  endtask

  // Ticks are counted edges; the pin trails the waveform by one clock
  task automatic step(input int n);
    @(posedge clk_i);
    tick_i <= 1'b1;
    repeat (n) @(posedge clk_i);
    tick_i <= 1'b0;
    #1;
  endtask

  task automatic pinc(input logic exp);
    @(posedge clk_i);
    #1;
    chk1("pin line", exp, line);
  endtask

  task automatic do_reset;
    @(posedge clk_i);
    sys_rst_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    sys_rst_i <= 1'b0;
  endtask

  function automatic logic [7:0] ctl(input logic [1:0] m, input logic [1:0] a);
    return {1'b0, 3'h1, a, m};
  endfunction

  task automatic finish_test;
    $display("checks %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial
  begin
    do_reset();
    step(5);
    cnt(8'h00);
    wr(timer8_pkg::ADDR_CTRL, ctl(timer8_pkg::MODE_NORMAL, timer8_pkg::ACT_OFF));
    repeat (5) @(posedge clk_i);
    cnt(8'h00);
    wr(timer8_pkg::ADDR_COUNT, 8'hFE);
    cnt(8'hFE);
    step(1);
    cnt(8'hFF);
    chk1("overflow", 1'b0, overflow_flag_o);
    step(1);
    cnt(8'h00);
    chk1("overflow", 1'b1, overflow_flag_o);
    step(1);
    chk1("overflow", 1'b1, overflow_flag_o);
    wr(timer8_pkg::ADDR_FLAGS, 8'h00);
    chk1("overflow", 1'b1, overflow_flag_o);
    wr(timer8_pkg::ADDR_FLAGS, 8'h01);
    chk1("overflow", 1'b0, overflow_flag_o);
    $display("test normal done");

    do_reset();
    wr(timer8_pkg::ADDR_CTRL, ctl(timer8_pkg::MODE_CLEAR, timer8_pkg::ACT_TOGGLE));
    wr(timer8_pkg::ADDR_COMPARE, 8'h03);
    @(posedge clk_i);
    #1;
    chk1("pin enable", 1'b0, wave_pin_oe_o);
    @(posedge clk_i);
    pin_dir_out_i <= 1'b1;
    step(4);
    cnt(8'h00);
    chk1("pin enable", 1'b1, wave_pin_oe_o);
    pinc(1'b1);
    step(1);
    cnt(8'h01);
    chk1("match", 1'b1, match_flag_o);
    wr(timer8_pkg::ADDR_FLAGS, 8'h02);
    chk1("match", 1'b0, match_flag_o);
    wr(timer8_pkg::ADDR_COUNT, 8'h0A);
    step(245);
    cnt(8'hFF);
    chk1("overflow", 1'b0, overflow_flag_o);
    step(1);
    cnt(8'h00);
    chk1("overflow", 1'b1, overflow_flag_o);
    $display("test clear on match done");

    do_reset();
    wr(timer8_pkg::ADDR_CTRL, ctl(timer8_pkg::MODE_FAST, timer8_pkg::ACT_CLR));
    wr(timer8_pkg::ADDR_COUNT, 8'hFD);
    wr(timer8_pkg::ADDR_COMPARE, 8'h80);
    rdc("compare", timer8_pkg::ADDR_COMPARE, 8'h80);
    step(2);
    cnt(8'hFF);
    chk1("overflow", 1'b0, overflow_flag_o);
    step(1);
    cnt(8'h00);
    chk1("overflow", 1'b1, overflow_flag_o);
    pinc(1'b1);
    wr(timer8_pkg::ADDR_COMPARE, 8'h30);
    step(8'h31);
    pinc(1'b1);
    step(8'h50);
    cnt(8'h81);
    pinc(1'b0);
    step(8'h7F);
    cnt(8'h00);
    pinc(1'b1);
    step(8'h31);
    pinc(1'b0);
    $display("test fast pwm done");

    do_reset();
    wr(timer8_pkg::ADDR_CTRL, ctl(timer8_pkg::MODE_PHASE, timer8_pkg::ACT_CLR));
    wr(timer8_pkg::ADDR_COMPARE, 8'h40);
    step(255);
    cnt(8'hFF);
    step(1);
    cnt(8'hFE);
    pinc(1'b0);
    step(8'hBE);
    cnt(8'h40);
    step(1);
    pinc(1'b1);
    step(8'h3F);
    cnt(8'h00);
    step(1);
    cnt(8'h01);
    chk1("overflow", 1'b1, overflow_flag_o);
    step(8'h40);
    cnt(8'h41);
    pinc(1'b0);
    $display("test phase correct done");

    do_reset();
    wr(timer8_pkg::ADDR_CTRL, ctl(timer8_pkg::MODE_FAST, timer8_pkg::ACT_TOGGLE));
    step(1);
    pinc(1'b1);
    wr(timer8_pkg::ADDR_COMPARE, 8'h10);
    step(8'hFF);
    step(8'h11);
    cnt(8'h11);
    pinc(1'b0);
    wr(timer8_pkg::ADDR_CTRL, ctl(timer8_pkg::MODE_FAST, timer8_pkg::ACT_CLR));
    wr(timer8_pkg::ADDR_COMPARE, 8'h00);
    step(8'hEF);
    pinc(1'b1);
    step(1);
    pinc(1'b0);
    wr(timer8_pkg::ADDR_CTRL, ctl(timer8_pkg::MODE_FAST, timer8_pkg::ACT_SET));
    wr(timer8_pkg::ADDR_COMPARE, 8'h20);
    step(8'hFF);
    step(8'h21);
    pinc(1'b1);
    wr(timer8_pkg::ADDR_COMPARE, 8'hFF);
    step(8'hDF);
    pinc(1'b0);
    step(256);
    cnt(8'h00);
    pinc(1'b0);
    $display("test fast pwm extremes done");

    do_reset();
    wr(timer8_pkg::ADDR_CTRL, ctl(timer8_pkg::MODE_PHASE, timer8_pkg::ACT_CLR));
    wr(timer8_pkg::ADDR_COMPARE, 8'hFF);
    step(256);
    step(510);
    pinc(1'b1);
    wr(timer8_pkg::ADDR_COMPARE, 8'h40);
    step(509);
    pinc(1'b1);
    step(1);
    pinc(1'b0);
    do_reset();
    wr(timer8_pkg::ADDR_CTRL, ctl(timer8_pkg::MODE_PHASE, timer8_pkg::ACT_SET));
    wr(timer8_pkg::ADDR_COUNT, 8'h80);
    wr(timer8_pkg::ADDR_COMPARE, 8'h40);
    step(8'h80);
    pinc(1'b1);
    step(8'hBF);
    cnt(8'h3F);
    pinc(1'b0);
    $display("test phase correct extremes done");
    finish_test();
  end

  // Cuts a hung run short
  initial
  begin
    repeat (50000) @(posedge clk_i);
    miscompares++;
    finish_test();
  end
endmodule
